// ===== tb/osc_model.sv
// Main oscillator model for the standby bench
`timescale 1ns/100ps

module osc_model #(
	parameter int START_DLY = 6
) (
	// Clock
	input wire logic mclk_i,
	// Oscillator control
	input wire logic osc_en_i,
	output logic osc_running_o
);
	int cnt = 0;

	initial osc_running_o = 1'b0;

	always @(posedge mclk_i) begin
		if (!osc_en_i) begin
			cnt <= 0;
			osc_running_o <= 1'b0;
		end else if (cnt < START_DLY) begin
			cnt <= cnt + 1;
		end else begin
			osc_running_o <= 1'b1;
		end
	end
endmodule : osc_model

// ===== tb/tb_top.sv
// Self-checking bench for the standby mode controller
`timescale 1ns/100ps
`include "standby_defs.svh"

module tb_top;
	import standby_pkg::*;
	localparam int DLY = 6;
	localparam int L15 = 20;
	localparam int L17 = 40;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	reg_req_s reg_i = '0;
	cpu_cmd_s cmd_i = '0;
	irq_in_s irq_i = '0;
	clk_cfg_s clk_cfg_i = '0;
	logic osc_running_i;
	logic [7:0] reg_rdata_o;
	logic cpu_clk_en_o, osc_en_o, retain_o, irq_hold_o, timer16_run_o;
	logic resume_vector_o, resume_next_o, reset_proc_o;
	int errors = 0;
	int n_tests = 0;
	int n;
	int lens [3] = '{4096, L15, L17};
	logic [2:0] ev;

	always #5 mclk_i = ~mclk_i;

	standby_mode_controller #(
		.SETTLE_CYC_15(18'h00014),
		.SETTLE_CYC_17(18'h00028)
	) standby_mode_controller_inst (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.reg_i(reg_i),
		.reg_rdata_o(reg_rdata_o),
		.cmd_i(cmd_i),
		.irq_i(irq_i),
		.clk_cfg_i(clk_cfg_i),
		.osc_running_i(osc_running_i),
		.cpu_clk_en_o(cpu_clk_en_o),
		.osc_en_o(osc_en_o),
		.retain_o(retain_o),
		.irq_hold_o(irq_hold_o),
		.timer16_run_o(timer16_run_o),
		.resume_vector_o(resume_vector_o),
		.resume_next_o(resume_next_o),
		.reset_proc_o(reset_proc_o)
	);

	osc_model #(.START_DLY(DLY)) osc_model_inst (
		.mclk_i(mclk_i),
		.osc_en_i(osc_en_o),
		.osc_running_o(osc_running_i)
	);

	task automatic print_verdict();
		$display("tests %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_rng(input int got, input int lo, input int hi);
		n_tests++;
		if (got < lo || got > hi) begin
			errors++;
			$display("[ERR] t=%0t got=%0h exp=%0h..%0h", $time, got, lo, hi);
		end
	endtask : chk_rng

	// Counts edges until a release pulse, bounded
	task automatic wait_ev(input int maxc);
		n = 0;
		ev = 3'h0;
		while (ev === 3'h0 && n < maxc) begin
			@(posedge mclk_i);
			#1;
			n++;
			ev = {resume_vector_o, resume_next_o, reset_proc_o};
		end
		if (ev === 3'h0) begin
			errors++;
			print_verdict();
		end
	endtask : wait_ev

	task automatic reg_acc(input logic [15:0] a, input logic w, input logic [7:0] d);
		@(posedge mclk_i);
		reg_i <= '{addr: a, wr: w, rd: !w, wdata: d};
		@(posedge mclk_i);
		reg_i <= '0;
		#1;
		if (!w) begin
			chk(reg_rdata_o, d);
		end
	endtask : reg_acc

	// Issues halt or stop and checks the clock controls
	task automatic enter(input logic stop);
		@(posedge mclk_i);
		cmd_i <= '{halt_exec: !stop, stop_exec: stop, flag_access: 1'b0};
		@(posedge mclk_i);
		cmd_i <= '0;
		#1;
		chk(cpu_clk_en_o, 1'b0);
		chk(retain_o, 1'b1);
		chk(osc_en_o, !stop);
	endtask : enter

	task automatic set_irq(input logic m, input logic g, input logic nm);
		@(posedge mclk_i);
		irq_i <= '{req: 24'h000001, mask: {23'h0, m}, global_en: g, nmi: nm};
	endtask : set_irq

	initial begin
		repeat (8) @(posedge mclk_i);
		rst_i <= 1'b0;
		#1;
		chk(osc_en_o, 1'b1);
		wait_ev(200);
		chk(ev, 3'h1);
		chk_rng(n, L15, L15 + 3);
		$display("test reset done");
		reg_acc(16'hFFFA, 1'b0, 8'h04);
		reg_acc(16'hFFFA, 1'b1, 8'h00);
		reg_acc(16'hFFFA, 1'b0, 8'h00);
		reg_acc(16'hFFF9, 1'b1, 8'h02);
		reg_acc(16'hFFFA, 1'b0, 8'h00);
		reg_acc(16'hFFF9, 1'b0, 8'h00);
		@(posedge mclk_i);
		cmd_i.flag_access <= 1'b1;
		@(posedge mclk_i);
		cmd_i.flag_access <= 1'b0;
		#1;
		chk(irq_hold_o, 1'b1);
		$display("test registers done");
		// Halt: masked stays, then vector, next and non-maskable release
		for (int i = 0; i < 3; i++) begin
			// Subclock halt with main clock off; 24-bit mode only on the second pass
			clk_cfg_i <= '{sub_clk_mode: 1'b1, main_clk_stopped: 1'b1, timer_24bit: i == 1};
			enter(1'b0);
			chk(timer16_run_o, i == 1);
			set_irq(1'b1, 1'b1, 1'b0);
			repeat (15) @(posedge mclk_i);
			#1;
			chk(cpu_clk_en_o, 1'b0);
			set_irq(i == 2, i == 0, i == 2);
			wait_ev(40);
			chk(ev, (i == 1) ? 3'h2 : 3'h4);
			chk_rng(n, (i == 1) ? 2 : 10, (i == 1) ? 3 : 11);
			chk(cpu_clk_en_o, 1'b1);
			irq_i <= '0;
		end
		$display("test halt done");
		for (int i = 0; i < 3; i++) begin
			reg_acc(16'hFFFA, 1'b1, {5'h00, 3'(2 * i)});
			enter(1'b1);
			set_irq(1'b1, 1'b1, 1'b1);
			repeat (10) @(posedge mclk_i);
			#1;
			chk(osc_en_o, 1'b0);
			set_irq(1'b0, i != 1, 1'b0);
			wait_ev(lens[i] + 50);
			chk(ev, (i == 1) ? 3'h2 : 3'h4);
			chk_rng(n, lens[i] + DLY, lens[i] + DLY + 5);
			irq_i <= '0;
		end
		// Stop with an unmasked request already pending
		set_irq(1'b0, 1'b0, 1'b0);
		@(posedge mclk_i);
		cmd_i.stop_exec <= 1'b1;
		@(posedge mclk_i);
		cmd_i.stop_exec <= 1'b0;
		#1;
		chk(osc_en_o, 1'b1);
		wait_ev(L17 + 20);
		chk(ev, 3'h2);
		chk_rng(n, L17, L17 + 4);
		irq_i <= '0;
		$display("test stop done");
		// Reset inside halt, then inside stop
		for (int i = 0; i < 2; i++) begin
			enter(i == 1);
			@(posedge mclk_i);
			rst_i <= 1'b1;
			repeat (2) @(posedge mclk_i);
			rst_i <= 1'b0;
			wait_ev(100);
			chk(ev, 3'h1);
			chk_rng(n, L15, L15 + DLY + 4);
		end
		$display("test reset in standby done");
		print_verdict();
	end
endmodule : tb_top

// ===== verilog/settle_counter.sv
// Oscillator settling counter
`timescale 1ns/100ps

module settle_counter (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Control
	input wire logic start_i,
	input wire standby_pkg::settle_len_t len_i,
	input wire logic osc_running_i,
	// Status
	output logic done_o,
	output logic busy_o
);
	import standby_pkg::*;

	settle_len_t count;
	settle_len_t next_count;
	logic next_busy;
	logic next_done;

	// Next count; holds while the oscillator has not restarted
	always_comb begin
		next_count = count;
		next_busy = busy_o;
		next_done = 1'b0;
		if (start_i) begin
			next_count = '0;
			next_busy = 1'b1;
		end else if (busy_o && osc_running_i) begin
			if (count == len_i - settle_len_t'(1)) begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end else begin
				next_count = count + settle_len_t'(1);
			end
		end
	end

	// Counter registers
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			count <= '0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			count <= next_count;
			busy_o <= next_busy;
			done_o <= next_done;
		end
	end

	a_count_waits_osc: assert property (@(posedge mclk_i) disable iff (rst_i)
		(busy_o && !osc_running_i && !start_i) |=> ($stable(count) && !done_o))
		else $error("settle count moved without oscillation");

endmodule : settle_counter

// ===== verilog/standby_defs.svh
// Constants for the standby mode controller
`ifndef STANDBY_DEFS_SVH
`define STANDBY_DEFS_SVH

// Settle-select register location and reset value
`define OSC_SEL_ADDR 16'hFFFA
`define OSC_SEL_RESET 3'h4
`define OSC_SEL_CODE_W 3

// Settle-select codes
`define CODE_2P12 3'h0
`define CODE_2P15 3'h2
`define CODE_2P17 3'h4

// Settling waits as powers of two of main oscillator cycles
`define SETTLE_EXP_12 12
`define SETTLE_EXP_15 15
`define SETTLE_EXP_17 17
`define SETTLE_CNT_W 18
`define SETTLE_CYC_12 (18'h00001 << `SETTLE_EXP_12)
`define SETTLE_CYC_15_DEF (18'h00001 << `SETTLE_EXP_15)
`define SETTLE_CYC_17_DEF (18'h00001 << `SETTLE_EXP_17)

// Halt release latency loads, in CPU clocks
`define RESUME_CNT_W 4
`define RESUME_VEC_CYC 4'h9
`define RESUME_NEXT_CYC 4'h1

// Interrupt source count (three flag bytes)
`define IRQ_SRC_W 24

`endif

// ===== verilog/standby_mode_controller.sv
// Standby controller: halt, stop, settling wait and release sequencing
`timescale 1ns/100ps
`include "standby_defs.svh"

module standby_mode_controller #(
	parameter standby_pkg::settle_len_t SETTLE_CYC_15 = `SETTLE_CYC_15_DEF,
	parameter standby_pkg::settle_len_t SETTLE_CYC_17 = `SETTLE_CYC_17_DEF
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Register access
	input wire standby_pkg::reg_req_s reg_i,
	output logic [7:0] reg_rdata_o,
	// CPU core and interrupt logic
	input wire standby_pkg::cpu_cmd_s cmd_i,
	input wire standby_pkg::irq_in_s irq_i,
	input wire standby_pkg::clk_cfg_s clk_cfg_i,
	input wire logic osc_running_i,
	// Clock and hold controls
	output logic cpu_clk_en_o,
	output logic osc_en_o,
	output logic retain_o,
	output logic irq_hold_o,
	output logic timer16_run_o,
	// Release events
	output logic resume_vector_o,
	output logic resume_next_o,
	output logic reset_proc_o
);
	import standby_pkg::*;

	// Settling length for a select code; prohibited codes take the longest wait
	function automatic settle_len_t len_of(input logic [`OSC_SEL_CODE_W-1:0] code,
			input settle_len_t c15, input settle_len_t c17);
		settle_len_t len;
		case (code)
			`CODE_2P12: len = `SETTLE_CYC_12;
			`CODE_2P15: len = c15;
			`CODE_2P17: len = c17;
			default: len = c17;
		endcase
		return len;
	endfunction : len_of

	// Any request whose mask flag is clear
	function automatic logic any_unmasked(input logic [`IRQ_SRC_W-1:0] req,
			input logic [`IRQ_SRC_W-1:0] mask);
		return |(req & ~mask);
	endfunction : any_unmasked

	state_e state;
	state_e next_state;
	resume_e kind;
	resume_e next_kind;
	logic [`RESUME_CNT_W-1:0] resume_cnt;
	logic [`RESUME_CNT_W-1:0] next_resume_cnt;
	settle_len_t settle_len;
	settle_len_t next_settle_len;
	logic settle_start;
	logic next_settle_start;
	logic reset_pend;
	logic next_reset_pend;
	logic [`OSC_SEL_CODE_W-1:0] sel_code;
	logic [`OSC_SEL_CODE_W-1:0] next_sel_code;
	logic [7:0] next_rdata;
	logic next_vec;
	logic next_next;
	logic next_rst_proc;
	logic next_cpu_clk_en;
	logic next_osc_en;
	logic next_retain;
	logic next_timer16;
	logic wake_irq;
	logic settle_done;
	logic settle_busy;

	assign wake_irq = any_unmasked(irq_i.req, irq_i.mask);

	// Settling counter on the main oscillator clock
	settle_counter u_settle (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.start_i(settle_start),
		.len_i(settle_len),
		.osc_running_i(osc_running_i),
		.done_o(settle_done),
		.busy_o(settle_busy)
	);

	// Select register write and read-back; upper bits read as zero
	always_comb begin
		next_sel_code = sel_code;
		next_rdata = 8'h00;
		if (reg_i.wr && reg_i.addr == `OSC_SEL_ADDR) begin
			next_sel_code = reg_i.wdata[`OSC_SEL_CODE_W-1:0];
		end
		if (reg_i.rd && reg_i.addr == `OSC_SEL_ADDR) begin
			next_rdata = {5'h00, sel_code};
		end
	end

	// Select register state
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			sel_code <= `OSC_SEL_RESET;
			reg_rdata_o <= 8'h00;
		end else begin
			sel_code <= next_sel_code;
			reg_rdata_o <= next_rdata;
		end
	end

	// Standby sequencing: next state and release events
	always_comb begin
		next_state = state;
		next_kind = kind;
		next_resume_cnt = resume_cnt;
		next_settle_len = settle_len;
		next_settle_start = 1'b0;
		next_reset_pend = reset_pend;
		next_vec = 1'b0;
		next_next = 1'b0;
		next_rst_proc = 1'b0;
		case (state)
			ST_RUN: begin
				if (cmd_i.stop_exec) begin
					next_settle_len = len_of(sel_code, SETTLE_CYC_15, SETTLE_CYC_17);
					if (wake_irq) begin
						next_state = ST_SETTLE;
						next_settle_start = 1'b1;
					end else begin
						next_state = ST_STOP;
					end
				end else if (cmd_i.halt_exec) begin
					next_state = ST_HALT;
				end
			end
			ST_HALT: begin
				if (irq_i.nmi) begin
					next_state = ST_RESUME;
					next_kind = WAKE_VECTOR;
					next_resume_cnt = `RESUME_VEC_CYC;
				end else if (wake_irq) begin
					next_state = ST_RESUME;
					if (irq_i.global_en) begin
						next_kind = WAKE_VECTOR;
						next_resume_cnt = `RESUME_VEC_CYC;
					end else begin
						next_kind = WAKE_NEXT;
						next_resume_cnt = `RESUME_NEXT_CYC;
					end
				end
			end
			ST_STOP: begin
				if (wake_irq) begin
					next_state = ST_SETTLE;
					next_settle_start = 1'b1;
				end
			end
			ST_SETTLE: begin
				if (settle_done) begin
					next_state = ST_RUN;
					if (reset_pend) begin
						next_reset_pend = 1'b0;
						next_rst_proc = 1'b1;
					end else if (irq_i.global_en) begin
						next_vec = 1'b1;
					end else begin
						next_next = 1'b1;
					end
				end
			end
			ST_RESUME: begin
				if (resume_cnt == `RESUME_NEXT_CYC) begin
					next_state = ST_RUN;
					next_vec = (kind == WAKE_VECTOR);
					next_next = (kind == WAKE_NEXT);
				end else begin
					next_resume_cnt = resume_cnt - `RESUME_NEXT_CYC;
				end
			end
			default: begin
				next_state = ST_RUN;
			end
		endcase
	end

	// Clock and hold controls from the next state
	always_comb begin
		next_cpu_clk_en = (next_state == ST_RUN);
		next_osc_en = (next_state != ST_STOP);
		next_retain = (next_state != ST_RUN);
		if (next_state == ST_STOP) begin
			next_timer16 = 1'b0;
		end else if (next_state == ST_HALT && clk_cfg_i.sub_clk_mode
				&& clk_cfg_i.main_clk_stopped) begin
			next_timer16 = clk_cfg_i.timer_24bit;
		end else begin
			next_timer16 = 1'b1;
		end
	end

	// Sequencer registers
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			// reset leaves any standby for the reset wait
			state <= ST_SETTLE;
			kind <= WAKE_NEXT;
			resume_cnt <= '0;
			// post-reset wait is the middle length
			settle_len <= SETTLE_CYC_15;
			settle_start <= 1'b1;
			reset_pend <= 1'b1;
			cpu_clk_en_o <= 1'b0;
			osc_en_o <= 1'b1;
			retain_o <= 1'b1;
			irq_hold_o <= 1'b0;
			timer16_run_o <= 1'b1;
			resume_vector_o <= 1'b0;
			resume_next_o <= 1'b0;
			reset_proc_o <= 1'b0;
		end else begin
			state <= next_state;
			kind <= next_kind;
			resume_cnt <= next_resume_cnt;
			settle_len <= next_settle_len;
			settle_start <= next_settle_start;
			reset_pend <= next_reset_pend;
			cpu_clk_en_o <= next_cpu_clk_en;
			osc_en_o <= next_osc_en;
			retain_o <= next_retain;
			irq_hold_o <= cmd_i.flag_access;
			timer16_run_o <= next_timer16;
			resume_vector_o <= next_vec;
			resume_next_o <= next_next;
			reset_proc_o <= next_rst_proc;
		end
	end

	// Checks on the sequencing

	a_hold_follows_access: assert property (@(posedge mclk_i) disable iff (rst_i)
		cmd_i.flag_access |=> irq_hold_o)
		else $error("interrupt hold missing during flag access");

	a_halt_gates_clock: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state == ST_RUN && cmd_i.halt_exec && !cmd_i.stop_exec)
		|=> (!cpu_clk_en_o && osc_en_o && retain_o))
		else $error("halt did not gate the CPU clock");

	a_stop_kills_osc: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state == ST_RUN && cmd_i.stop_exec && !wake_irq) |=> (!osc_en_o && !timer16_run_o))
		else $error("stop left the oscillator running");

	a_short_code_len: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state == ST_RUN && cmd_i.stop_exec && sel_code == `CODE_2P12)
		|=> (settle_len == `SETTLE_CYC_12))
		else $error("code 000 did not select the short wait");

	a_reset_wait_len: assert property (@(posedge mclk_i)
		$fell(rst_i) |-> (settle_len == SETTLE_CYC_15 && sel_code == `OSC_SEL_RESET
		&& state == ST_SETTLE))
		else $error("reset wait length or select value wrong");

	a_masked_keeps_halt: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state == ST_HALT && !wake_irq && !irq_i.nmi) |=> (state == ST_HALT && !cpu_clk_en_o))
		else $error("masked request released halt");

	a_vector_latency: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state == ST_HALT && wake_irq && irq_i.global_en)
		|=> (!resume_vector_o && !cpu_clk_en_o) [*8] ##1 (!resume_vector_o && !cpu_clk_en_o)
		##1 (resume_vector_o && cpu_clk_en_o))
		else $error("vectored halt release not in ten clocks");

	a_next_latency: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state == ST_HALT && wake_irq && !irq_i.global_en && !irq_i.nmi)
		|-> ##1 !cpu_clk_en_o ##1 (resume_next_o && cpu_clk_en_o && !resume_vector_o))
		else $error("plain halt release not in two clocks");

	a_nmi_vectors: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state == ST_HALT && irq_i.nmi) |-> ##10 (resume_vector_o && !resume_next_o))
		else $error("non-maskable request did not vector");

	a_stop_pending: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state == ST_RUN && cmd_i.stop_exec && wake_irq)
		|=> (state == ST_SETTLE && osc_en_o && !cpu_clk_en_o))
		else $error("stop with pending request did not settle in halt");

	a_settle_before_run: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state == ST_SETTLE && !settle_done) |=> !cpu_clk_en_o)
		else $error("CPU clock resumed before settling ended");

endmodule : standby_mode_controller

// ===== verilog/standby_pkg.sv
// Types shared by the standby mode controller files
`include "standby_defs.svh"

package standby_pkg;

	// Controller states
	typedef enum logic [2:0] {
		ST_RUN,
		ST_HALT,
		ST_STOP,
		ST_SETTLE,
		ST_RESUME
	} state_e;

	// How execution resumes after a release
	typedef enum logic {
		WAKE_NEXT,
		WAKE_VECTOR
	} resume_e;

	// Instruction strobes from the CPU core
	typedef struct packed {
		logic halt_exec;
		logic stop_exec;
		logic flag_access;
	} cpu_cmd_s;

	// Request, mask and enable state from the interrupt logic
	typedef struct packed {
		logic [`IRQ_SRC_W-1:0] req;
		logic [`IRQ_SRC_W-1:0] mask;
		logic global_en;
		logic nmi;
	} irq_in_s;

	// Register access from the CPU data path
	typedef struct packed {
		logic [15:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} reg_req_s;

	// Clocking situation seen by the 16-bit timer
	typedef struct packed {
		logic sub_clk_mode;
		logic main_clk_stopped;
		logic timer_24bit;
	} clk_cfg_s;

	typedef logic [`SETTLE_CNT_W-1:0] settle_len_t;

endpackage : standby_pkg
